// >>> udp_mac_fifo_adapter.sv
// Purpose: bridge between an offload core's show-ahead FIFO ports and MAC packet streams
// Assumes: MAC clocks are much slower than ref_clk and are sampled as pins
// Notes: tx side forwards only whole stored packets; rx side drops what cannot fit
//
// What this block does
// - Serves core side plus separate MAC transmit and MAC receive timing
// - 256-bit show-ahead FIFO ports to core, 256-bit valid/ready tx and valid-only rx streams to MAC
// - One transmit and one receive buffer, 512 entries of 258 bits each
// - Transmit and receive paths independent; core writes tx and reads rx buffer directly
// - Written-packet counter steps on each stored end word, passed toward tx logic
// - Read-packet counter steps on each first word; remaining is their difference
// - Store only bit 4 of final-word empty count, which is 0x16 or 0x04
// - Leave idle only with packets remaining and tx buffer not empty
// - Update state lasts one cycle: drop remaining count, read first word
// - In transfer, buffer read follows MAC accept and loads the output word
// - Transmit valid stays high until the end word is accepted
// - Without accept no read, so the presented word stays put
// - After end word is accepted, go idle and drop transmit valid
// - Admit a received packet only while rx fill count is below 224
// - Rx write enable follows MAC valid; write data is registered in the same clock as it
// - Rx returns to idle on a valid word marked end of packet
// - Fill 224 or more: discard until valid end word, writes held off
`timescale 1ns/1ps
module udp_mac_fifo_adapter #(
	parameter int FIFO_DEPTH = adapter_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// core transmit write port
	input wire logic core_tx_write_enable,
	input wire logic [adapter_pkg::WORD_W-1:0] core_tx_word,
	input wire logic core_tx_packet_end,
	input wire logic [adapter_pkg::EMPTY_W-1:0] tx_final_word_empty_bytes,
	output logic core_tx_write_ready,
	// core receive read port
	input wire logic core_rx_read_enable,
	output logic core_rx_word_valid,
	output logic [adapter_pkg::WORD_W-1:0] core_rx_word,
	output logic core_rx_packet_start,
	output logic core_rx_packet_end,
	// MAC transmit stream
	input wire logic mac_tx_clock,
	input wire logic mac_tx_accept,
	output logic [adapter_pkg::WORD_W-1:0] mac_tx_word,
	output logic mac_tx_word_valid,
	output logic mac_tx_packet_start,
	output logic mac_tx_packet_end,
	output logic [adapter_pkg::EMPTY_W-1:0] mac_tx_empty_bytes,
	// MAC receive stream
	input wire logic mac_rx_clock,
	input wire logic mac_rx_word_valid,
	input wire logic mac_rx_packet_start,
	input wire logic mac_rx_packet_end,
	input wire logic [adapter_pkg::WORD_W-1:0] mac_rx_word
);
	localparam int WW = adapter_pkg::WORD_W;
	localparam int EW = adapter_pkg::ENTRY_W;
	localparam int CNT_W = adapter_pkg::PKT_CNT_W;
	localparam int RX_PIN_W = WW + 4;

	////////////////////////////////////////////////////////////////////////////
	// buffers

	fifo_link_if #(.WIDTH(EW), .CW(adapter_pkg::FILL_W)) tx_link ();
	fifo_link_if #(.WIDTH(EW), .CW(adapter_pkg::FILL_W)) rx_link ();

	show_ahead_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH), .CW(adapter_pkg::FILL_W)) tx_buffer (
		.ref_clk(ref_clk),
		.reset(reset),
		.port(tx_link.store)
	);

	show_ahead_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH), .CW(adapter_pkg::FILL_W)) rx_buffer (
		.ref_clk(ref_clk),
		.reset(reset),
		.port(rx_link.store)
	);

	////////////////////////////////////////////////////////////////////////////
	// MAC pin sampling and clock edge detection

	logic [1:0] tx_pins;
	logic [RX_PIN_W-1:0] rx_pins;
	logic tx_clock_seen, rx_clock_seen;
	logic tx_tick, rx_tick;
	logic tx_accept_sampled;
	logic rx_valid_sampled, rx_start_sampled, rx_end_sampled;
	logic [WW-1:0] rx_word_sampled;

	level_sync #(.WIDTH(2)) tx_pin_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin_level({mac_tx_clock, mac_tx_accept}),
		.synced(tx_pins)
	);

	level_sync #(.WIDTH(RX_PIN_W)) rx_pin_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin_level({mac_rx_clock, mac_rx_word_valid, mac_rx_packet_start,
			mac_rx_packet_end, mac_rx_word}),
		.synced(rx_pins)
	);

	// clock and data pass the same stages, so data seen at the edge is the sampled value
	always_comb begin
		tx_accept_sampled = tx_pins[0];
		tx_tick = tx_pins[1] && !tx_clock_seen;
		rx_word_sampled = rx_pins[WW-1:0];
		rx_end_sampled = rx_pins[WW];
		rx_start_sampled = rx_pins[WW+1];
		rx_valid_sampled = rx_pins[WW+2];
		rx_tick = rx_pins[WW+3] && !rx_clock_seen;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_clock_seen <= 1'b0;
			rx_clock_seen <= 1'b0;
		end else begin
			tx_clock_seen <= tx_pins[1];
			rx_clock_seen <= rx_pins[WW+3];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit write side and packet counters

	logic [CNT_W-1:0] written_count, next_written_count;
	logic [CNT_W-1:0] written_seen, next_written_seen;
	logic [CNT_W-1:0] read_count, next_read_count;
	logic [CNT_W-1:0] remaining_packet_count;
	logic [CNT_W-1:0] remaining_count_reg, next_remaining_count_reg;
	logic tx_fifo_is_empty;
	logic tx_fifo_read_enable;

	// the core drives the write port directly
	assign tx_link.wr_valid = core_tx_write_enable;
	assign tx_link.wr_data = {tx_final_word_empty_bytes[adapter_pkg::EMPTY_SELECT_BIT],
		core_tx_packet_end, core_tx_word};
	assign tx_link.rd_ready = tx_fifo_read_enable;
	assign core_tx_write_ready = tx_link.wr_ready;
	assign tx_fifo_is_empty = !tx_link.rd_valid;

	always_comb begin
		next_written_count = written_count;
		if (core_tx_write_enable && tx_link.wr_ready && core_tx_packet_end)
			next_written_count = written_count + adapter_pkg::PKT_ONE;
		// one stage toward the transmit logic, taken on whole values only
		next_written_seen = written_count;
		remaining_packet_count = written_seen - read_count;
		next_remaining_count_reg = remaining_packet_count;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			written_count <= adapter_pkg::PKT_ZERO;
			written_seen <= adapter_pkg::PKT_ZERO;
			remaining_count_reg <= adapter_pkg::PKT_ZERO;
		end else begin
			written_count <= next_written_count;
			written_seen <= next_written_seen;
			remaining_count_reg <= next_remaining_count_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit state machine

	adapter_pkg::tx_state_type transmit_fsm, next_transmit_fsm;
	logic [WW-1:0] next_mac_tx_word;
	logic next_mac_tx_word_valid, next_mac_tx_packet_start, next_mac_tx_packet_end;
	logic [adapter_pkg::EMPTY_W-1:0] next_mac_tx_empty_bytes;
	logic head_end, head_wide;

	always_comb begin
		head_end = tx_link.rd_data[adapter_pkg::END_BIT];
		head_wide = tx_link.rd_data[adapter_pkg::AUX_BIT];
		next_transmit_fsm = transmit_fsm;
		next_read_count = read_count;
		next_mac_tx_word = mac_tx_word;
		next_mac_tx_word_valid = mac_tx_word_valid;
		next_mac_tx_packet_start = mac_tx_packet_start;
		next_mac_tx_packet_end = mac_tx_packet_end;
		next_mac_tx_empty_bytes = mac_tx_empty_bytes;
		tx_fifo_read_enable = 1'b0;
		case (transmit_fsm)
			adapter_pkg::idle_state: begin
				if (tx_tick && remaining_count_reg != adapter_pkg::PKT_ZERO
					&& !tx_fifo_is_empty)
					next_transmit_fsm = adapter_pkg::packet_update_state;
			end
			adapter_pkg::packet_update_state: begin
				tx_fifo_read_enable = 1'b1;
				next_read_count = read_count + adapter_pkg::PKT_ONE;
				next_mac_tx_word = tx_link.rd_data[WW-1:0];
				next_mac_tx_word_valid = 1'b1;
				next_mac_tx_packet_start = 1'b1;
				next_mac_tx_packet_end = head_end;
				next_mac_tx_empty_bytes = head_wide ? adapter_pkg::EMPTY_WIDE
					: adapter_pkg::EMPTY_NARROW;
				next_transmit_fsm = adapter_pkg::transfer_state;
			end
			adapter_pkg::transfer_state: begin
				// without accept nothing is read and the word is held
				if (tx_tick && tx_accept_sampled) begin
					if (mac_tx_packet_end) begin
						next_mac_tx_word_valid = 1'b0;
						next_mac_tx_packet_start = 1'b0;
						next_mac_tx_packet_end = 1'b0;
						next_transmit_fsm = adapter_pkg::idle_state;
					end else if (!tx_fifo_is_empty) begin
						tx_fifo_read_enable = 1'b1;
						next_mac_tx_word = tx_link.rd_data[WW-1:0];
						next_mac_tx_packet_start = 1'b0;
						next_mac_tx_packet_end = head_end;
						next_mac_tx_empty_bytes = head_wide ? adapter_pkg::EMPTY_WIDE
							: adapter_pkg::EMPTY_NARROW;
					end
				end
			end
			default: begin
				next_transmit_fsm = adapter_pkg::idle_state;
				next_mac_tx_word_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			transmit_fsm <= adapter_pkg::idle_state;
			read_count <= adapter_pkg::PKT_ZERO;
			mac_tx_word <= '0;
			mac_tx_word_valid <= 1'b0;
			mac_tx_packet_start <= 1'b0;
			mac_tx_packet_end <= 1'b0;
			mac_tx_empty_bytes <= '0;
		end else begin
			transmit_fsm <= next_transmit_fsm;
			read_count <= next_read_count;
			mac_tx_word <= next_mac_tx_word;
			mac_tx_word_valid <= next_mac_tx_word_valid;
			mac_tx_packet_start <= next_mac_tx_packet_start;
			mac_tx_packet_end <= next_mac_tx_packet_end;
			mac_tx_empty_bytes <= next_mac_tx_empty_bytes;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive state machine

	adapter_pkg::rx_state_type rx_fsm, next_rx_fsm;
	logic rx_fifo_write_enable, next_rx_fifo_write_enable;
	logic [EW-1:0] rx_fifo_write_word, next_rx_fifo_write_word;
	logic [adapter_pkg::FILL_W-1:0] rx_fifo_fill_count;
	logic rx_end_word;

	assign rx_fifo_fill_count = rx_link.fill_count;
	assign rx_link.wr_valid = rx_fifo_write_enable;
	assign rx_link.wr_data = rx_fifo_write_word;
	// the core drives the read port directly
	assign rx_link.rd_ready = core_rx_read_enable;
	assign core_rx_word_valid = rx_link.rd_valid;
	assign core_rx_word = rx_link.rd_data[WW-1:0];
	assign core_rx_packet_end = rx_link.rd_data[adapter_pkg::END_BIT];
	assign core_rx_packet_start = rx_link.rd_data[adapter_pkg::AUX_BIT];

	always_comb begin
		rx_end_word = rx_valid_sampled && rx_end_sampled;
		next_rx_fsm = rx_fsm;
		next_rx_fifo_write_enable = 1'b0;
		next_rx_fifo_write_word = rx_fifo_write_word;
		// data is registered one clock and written with the enable
		if (rx_tick)
			next_rx_fifo_write_word = {rx_start_sampled, rx_end_sampled, rx_word_sampled};
		case (rx_fsm)
			adapter_pkg::rx_idle_state: begin
				if (rx_tick && rx_valid_sampled && rx_start_sampled) begin
					if (rx_fifo_fill_count < adapter_pkg::RX_ADMIT_LIMIT) begin
						next_rx_fifo_write_enable = 1'b1;
						if (!rx_end_sampled)
							next_rx_fsm = adapter_pkg::rx_transfer_state;
					end else if (!rx_end_sampled) begin
						next_rx_fsm = adapter_pkg::discard_state;
					end
				end
			end
			adapter_pkg::rx_transfer_state: begin
				if (rx_tick) begin
					next_rx_fifo_write_enable = rx_valid_sampled;
					if (rx_end_word)
						next_rx_fsm = adapter_pkg::rx_idle_state;
				end
			end
			adapter_pkg::discard_state: begin
				// write enable stays low for the whole dropped packet
				if (rx_tick && rx_end_word)
					next_rx_fsm = adapter_pkg::rx_idle_state;
			end
			default: begin
				next_rx_fsm = adapter_pkg::rx_idle_state;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_fsm <= adapter_pkg::rx_idle_state;
			rx_fifo_write_enable <= 1'b0;
			rx_fifo_write_word <= '0;
		end else begin
			rx_fsm <= next_rx_fsm;
			rx_fifo_write_enable <= next_rx_fifo_write_enable;
			rx_fifo_write_word <= next_rx_fifo_write_word;
		end
	end
endmodule : udp_mac_fifo_adapter

// >>> adapter_pkg.sv
// Purpose: shared constants and state types for the packet FIFO adapter
// Assumes: one system clock samples both MAC-side clocks as plain inputs
// Notes: widths and thresholds follow the packet buffer sizing
package adapter_pkg;
	// stream word and buffer entry layout
	localparam int WORD_W = 256;
	localparam int ENTRY_W = 258;
	localparam int END_BIT = 256;
	localparam int AUX_BIT = 257;
	// buffer depth and the fill level that still admits a jumbo packet
	localparam int FIFO_DEPTH = 512;
	localparam int FILL_W = 10;
	localparam logic [FILL_W-1:0] RX_ADMIT_LIMIT = 10'h0E0;
	// final-word empty byte codes and the bit that tells them apart
	localparam int EMPTY_W = 5;
	localparam int EMPTY_SELECT_BIT = 4;
	localparam logic [EMPTY_W-1:0] EMPTY_WIDE = 5'h16;
	localparam logic [EMPTY_W-1:0] EMPTY_NARROW = 5'h04;
	// packet counters
	localparam int PKT_CNT_W = 16;
	localparam logic [PKT_CNT_W-1:0] PKT_ONE = 16'h0001;
	localparam logic [PKT_CNT_W-1:0] PKT_ZERO = 16'h0000;

	typedef enum logic [1:0] {
		idle_state = 2'h0,
		packet_update_state = 2'h1,
		transfer_state = 2'h2
	} tx_state_type;

	typedef enum logic [1:0] {
		rx_idle_state = 2'h0,
		rx_transfer_state = 2'h1,
		discard_state = 2'h2
	} rx_state_type;
endpackage : adapter_pkg

// >>> fifo_link_if.sv
// Purpose: fill and drain signals of one packet buffer
// Assumes: both sides on the system clock
// Notes: fill_count includes the word held in the output register
`timescale 1ns/1ps
interface fifo_link_if #(
	parameter int WIDTH = adapter_pkg::ENTRY_W,
	parameter int CW = adapter_pkg::FILL_W
);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	logic [CW-1:0] fill_count;

	modport store (
		input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data, fill_count
	);
	modport filler (
		output wr_valid, wr_data,
		input wr_ready, fill_count
	);
	modport drainer (
		output rd_ready,
		input rd_valid, rd_data
	);
endinterface : fifo_link_if

// >>> level_sync.sv
// Purpose: two-stage synchroniser for pins from outside the system clock
// Assumes: multi-bit words are only read when their qualifying clock edge is seen
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// pin side
	input wire logic [WIDTH-1:0] pin_level,
	// system side
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stage_one <= '0;
			synced <= '0;
		end else begin
			stage_one <= pin_level;
			synced <= stage_one;
		end
	end
endmodule : level_sync

// >>> show_ahead_fifo.sv
// Purpose: show-ahead packet buffer with registered head word
// Assumes: DEPTH is a power of two
// Notes: rd_data is valid whenever rd_valid is high; pop with rd_ready
`timescale 1ns/1ps
module show_ahead_fifo #(
	parameter int WIDTH = adapter_pkg::ENTRY_W,
	parameter int DEPTH = adapter_pkg::FIFO_DEPTH,
	parameter int CW = adapter_pkg::FILL_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// buffer port
	fifo_link_if.store port
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [CW-1:0] CAPACITY = CW'(DEPTH);
	localparam logic [CW-1:0] ONE = CW'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [CW-1:0] mem_count, next_mem_count, total, next_total;
	logic out_valid, next_out_valid, ready, next_ready;
	logic [WIDTH-1:0] out_word, next_out_word;
	logic push, pop, load;

	always_comb begin
		push = port.wr_valid && ready;
		pop = port.rd_ready && out_valid;
		load = (mem_count != '0) && (!out_valid || pop);
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = load ? rd_ptr + AW'(1) : rd_ptr;
		next_mem_count = mem_count;
		if (push && !load)
			next_mem_count = mem_count + ONE;
		else if (!push && load)
			next_mem_count = mem_count - ONE;
		next_total = total;
		if (push && !pop)
			next_total = total + ONE;
		else if (!push && pop)
			next_total = total - ONE;
		next_out_valid = load || (out_valid && !pop);
		next_out_word = load ? mem[rd_ptr] : out_word;
		next_ready = next_total < CAPACITY;
	end

	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wr_ptr] <= port.wr_data;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			mem_count <= '0;
			total <= '0;
			out_valid <= 1'b0;
			out_word <= '0;
			ready <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			mem_count <= next_mem_count;
			total <= next_total;
			out_valid <= next_out_valid;
			out_word <= next_out_word;
			ready <= next_ready;
		end
	end

	assign port.wr_ready = ready;
	assign port.rd_valid = out_valid;
	assign port.rd_data = out_word;
	assign port.fill_count = total;
endmodule : show_ahead_fifo

// >>> udp_mac_fifo_adapter_sva.sv
// Purpose: port checks of the packet adapter
// Assumes: mac_tx_accept moves only at falling MAC clock edges
// Notes: bound into every adapter instance
`timescale 1ns/1ps
module udp_mac_fifo_adapter_sva #(
	parameter int FIFO_DEPTH = adapter_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// core side
	input wire logic core_tx_write_enable,
	input wire logic core_tx_packet_end,
	input wire logic core_tx_write_ready,
	input wire logic core_rx_word_valid,
	// MAC transmit side
	input wire logic mac_tx_accept,
	input wire logic [adapter_pkg::WORD_W-1:0] mac_tx_word,
	input wire logic mac_tx_word_valid,
	input wire logic mac_tx_packet_start,
	input wire logic mac_tx_packet_end,
	input wire logic [adapter_pkg::EMPTY_W-1:0] mac_tx_empty_bytes
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// stored packets against started packets
	logic [15:0] stored;
	logic [15:0] started;
	logic [15:0] next_stored;
	logic [15:0] next_started;
	logic was_valid;
	logic next_was_valid;
	always_comb begin
		next_stored = stored;
		next_started = started;
		next_was_valid = mac_tx_word_valid;
		if (core_tx_write_enable && core_tx_write_ready && core_tx_packet_end)
			next_stored = stored + 16'h0001;
		if (mac_tx_word_valid && !was_valid)
			next_started = started + 16'h0001;
		if (reset) begin
			next_stored = 16'h0000;
			next_started = 16'h0000;
			next_was_valid = 1'b0;
		end
	end
	always_ff @(posedge ref_clk) begin
		stored <= next_stored;
		started <= next_started;
		was_valid <= next_was_valid;
	end
	////////////////////////////////////////
	sequence s_word_moved;
		mac_tx_word_valid && $past(mac_tx_word_valid) && !$stable(mac_tx_word);
	endsequence
	sequence s_end_taken;
		mac_tx_word_valid && mac_tx_packet_end ##1 !mac_tx_packet_end;
	endsequence
	property p_reset_quiet;
		$past(reset) |-> !mac_tx_word_valid && !core_rx_word_valid && !core_tx_write_ready;
	endproperty
	property p_ready_returns;
		$fell(reset) |-> ##[1:3] core_tx_write_ready;
	endproperty
	property p_valid_holds;
		mac_tx_word_valid && !mac_tx_packet_end |=> mac_tx_word_valid;
	endproperty
	property p_first_start;
		$rose(mac_tx_word_valid) |-> mac_tx_packet_start;
	endproperty
	property p_start_once;
		s_word_moved |-> !mac_tx_packet_start;
	endproperty
	property p_hold_on_stall;
		s_word_moved |-> $past(mac_tx_accept, 5);
	endproperty
	property p_end_closes;
		s_end_taken |-> !mac_tx_word_valid && !mac_tx_packet_start;
	endproperty
	property p_fell_after_end;
		$fell(mac_tx_word_valid) |-> $past(mac_tx_packet_end);
	endproperty
	property p_end_code;
		mac_tx_word_valid && mac_tx_packet_end |-> mac_tx_empty_bytes == adapter_pkg::EMPTY_WIDE
			|| mac_tx_empty_bytes == adapter_pkg::EMPTY_NARROW;
	endproperty
	property p_no_early_start;
		$rose(mac_tx_word_valid) |-> started < stored;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	a_ready_returns: assert property (p_ready_returns) else $error("ready late");
	a_valid_holds: assert property (p_valid_holds) else $error("valid dropped");
	a_first_start: assert property (p_first_start) else $error("no start flag");
	a_start_once: assert property (p_start_once) else $error("start repeated");
	a_hold_on_stall: assert property (p_hold_on_stall) else $error("word moved");
	a_end_closes: assert property (p_end_closes) else $error("valid after end");
	a_fell_after_end: assert property (p_fell_after_end) else $error("early drop");
	a_end_code: assert property (p_end_code) else $error("bad empty code");
	a_no_early_start: assert property (p_no_early_start) else $error("early start");
endmodule : udp_mac_fifo_adapter_sva
bind udp_mac_fifo_adapter udp_mac_fifo_adapter_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
	.ref_clk,
	.reset,
	.core_tx_write_enable,
	.core_tx_packet_end,
	.core_tx_write_ready,
	.core_rx_word_valid,
	.mac_tx_accept,
	.mac_tx_word,
	.mac_tx_word_valid,
	.mac_tx_packet_start,
	.mac_tx_packet_end,
	.mac_tx_empty_bytes
);

// >>> mac_far_end.sv
// Purpose: far-end stand-in for the MAC streams
// Assumes: both MAC clocks run free at 160 ns
// Notes: ready and rx lines move only on falling MAC clock edges
`timescale 1ns/1ps
module mac_far_end (
	// stream clocks
	output logic mac_tx_clock,
	output logic mac_rx_clock,
	// transmit stream
	input wire logic stall,
	input wire logic [adapter_pkg::WORD_W-1:0] mac_tx_word,
	input wire logic mac_tx_word_valid,
	input wire logic mac_tx_packet_start,
	input wire logic mac_tx_packet_end,
	input wire logic [adapter_pkg::EMPTY_W-1:0] mac_tx_empty_bytes,
	output logic mac_tx_accept,
	// receive stream
	output logic mac_rx_word_valid,
	output logic mac_rx_packet_start,
	output logic mac_rx_packet_end,
	output logic [adapter_pkg::WORD_W-1:0] mac_rx_word
);
	logic [adapter_pkg::WORD_W-1:0] tx_words[$];
	logic [6:0] tx_tags[$];
	logic [1:0] edge_cnt = 2'h0;
	initial begin
		mac_tx_clock = 1'b0;
		mac_tx_accept = 1'b1;
		#3.3;
		forever #80 mac_tx_clock = ~mac_tx_clock;
	end
	initial begin
		mac_rx_clock = 1'b0;
		mac_rx_word_valid = 1'b0;
		mac_rx_packet_start = 1'b0;
		mac_rx_packet_end = 1'b0;
		mac_rx_word = '0;
		#57.1;
		forever #80 mac_rx_clock = ~mac_rx_clock;
	end
	// ready low three edges in four while stalling
	always @(negedge mac_tx_clock) begin
		edge_cnt <= edge_cnt + 2'h1;
		mac_tx_accept <= !stall || edge_cnt == 2'h3;
	end
	always @(posedge mac_tx_clock) begin
		if (mac_tx_word_valid && mac_tx_accept) begin
			tx_words.push_back(mac_tx_word);
			tx_tags.push_back({mac_tx_packet_start, mac_tx_packet_end, mac_tx_empty_bytes});
		end
	end
	// one word per rx clock, data scrambled while idle
	task automatic send(input logic s, input logic e, input logic v,
			input logic [adapter_pkg::WORD_W-1:0] d);
		@(negedge mac_rx_clock);
		mac_rx_word_valid <= v;
		mac_rx_packet_start <= s;
		mac_rx_packet_end <= e;
		mac_rx_word <= v ? d : ~mac_rx_word;
		@(posedge mac_rx_clock);
	endtask : send
endmodule : mac_far_end

// >>> udp_mac_fifo_adapter_tb.sv
// Purpose: self-checking bench for the packet adapter
// Assumes: far end makes both MAC clocks
// Notes: core-side inputs move 1 ns after the ref_clk rising edge
`timescale 1ns/1ps
module udp_mac_fifo_adapter_tb;
	localparam int W = adapter_pkg::WORD_W;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic core_tx_write_enable = 1'b0;
	logic [W-1:0] core_tx_word = '0;
	logic core_tx_packet_end = 1'b0;
	logic [4:0] tx_final_word_empty_bytes = 5'h00;
	logic core_rx_read_enable = 1'b0;
	logic stall = 1'b0;
	logic core_tx_write_ready, core_rx_word_valid, core_rx_packet_start, core_rx_packet_end;
	logic [W-1:0] core_rx_word, mac_tx_word, mac_rx_word;
	logic mac_tx_clock, mac_rx_clock, mac_tx_accept, mac_tx_word_valid;
	logic mac_tx_packet_start, mac_tx_packet_end;
	logic mac_rx_word_valid, mac_rx_packet_start, mac_rx_packet_end;
	logic [4:0] mac_tx_empty_bytes;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	udp_mac_fifo_adapter dut (.ref_clk, .reset, .core_tx_write_enable, .core_tx_word,
		.core_tx_packet_end, .tx_final_word_empty_bytes, .core_tx_write_ready,
		.core_rx_read_enable, .core_rx_word_valid, .core_rx_word, .core_rx_packet_start,
		.core_rx_packet_end, .mac_tx_clock, .mac_tx_accept, .mac_tx_word, .mac_tx_word_valid,
		.mac_tx_packet_start, .mac_tx_packet_end, .mac_tx_empty_bytes, .mac_rx_clock,
		.mac_rx_word_valid, .mac_rx_packet_start, .mac_rx_packet_end, .mac_rx_word);
	mac_far_end far (.mac_tx_clock, .mac_rx_clock, .stall, .mac_tx_word, .mac_tx_word_valid,
		.mac_tx_packet_start, .mac_tx_packet_end, .mac_tx_empty_bytes, .mac_tx_accept,
		.mac_rx_word_valid, .mac_rx_packet_start, .mac_rx_packet_end, .mac_rx_word);
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////
	task automatic tally_and_finish();
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	function automatic logic [W-1:0] mk(input logic [31:0] k);
		return {8{k}};
	endfunction : mk
	task automatic pause(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : pause
	////////////////////////////////////////
	task automatic do_reset();
		int t = 0;
		reset = 1'b1;
		pause(2);
		check("reset tx valid", mac_tx_word_valid, 0);
		check("reset rx valid", core_rx_word_valid, 0);
		reset = 1'b0;
		while (core_tx_write_ready !== 1'b1 && t < 10) begin
			pause(1);
			t++;
		end
		check("ready after reset", core_tx_write_ready, 1);
	endtask : do_reset
	task automatic send_pkt(input int n, input int base, input logic [4:0] emp);
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			while (core_tx_write_ready !== 1'b1 && t < 100) begin
				pause(1);
				t++;
			end
			core_tx_write_enable = 1'b1;
			core_tx_word = mk(base + i);
			core_tx_packet_end = i == n - 1;
			tx_final_word_empty_bytes = emp;
			pause(1);
		end
		core_tx_write_enable = 1'b0;
		core_tx_packet_end = 1'b0;
	endtask : send_pkt
	task automatic cmp_tx(input int off, input int n, input int base, input logic [4:0] emp);
		logic [6:0] tag;
		int t = 0;
		while (far.tx_words.size() < off + n && t < 3000) begin
			pause(1);
			t++;
		end
		for (int i = 0; i < n; i++) begin
			tag = far.tx_tags[off + i];
			check("tx word", far.tx_words[off + i], mk(base + i));
			check("tx start", tag[6], i == 0);
			check("tx end", tag[5], i == n - 1);
		end
		check("tx empty code", tag[4:0], emp);
	endtask : cmp_tx
	task automatic t_tx(input int n, input int base, input logic [4:0] emp, input logic slow);
		stall = slow;
		far.tx_words.delete();
		far.tx_tags.delete();
		send_pkt(n, base, emp);
		cmp_tx(0, n, base, emp);
	endtask : t_tx
	task automatic t_tx_pair();
		stall = 1'b0;
		far.tx_words.delete();
		far.tx_tags.delete();
		send_pkt(2, 400, 5'h16);
		pause(1);
		send_pkt(3, 500, 5'h04);
		cmp_tx(0, 2, 400, 5'h16);
		cmp_tx(2, 3, 500, 5'h04);
	endtask : t_tx_pair
	task automatic send_rx(input int n, input int base, input logic gap);
		for (int i = 0; i < n; i++) begin
			if (gap && i == 1)
				far.send(0, 0, 0, mk(0));
			far.send(i == 0, i == n - 1, 1'b1, mk(base + i));
		end
		far.send(0, 0, 0, mk(0));
	endtask : send_rx
	task automatic drain(input int n, input int base);
		int t;
		for (int i = 0; i < n; i++) begin
			t = 0;
			pause(1);
			while (core_rx_word_valid !== 1'b1 && t < 200) begin
				pause(1);
				t++;
			end
			check("rx word", core_rx_word, mk(base + i));
			check("rx start", core_rx_packet_start, i == 0);
			check("rx end", core_rx_packet_end, i == n - 1);
			core_rx_read_enable = 1'b1;
			pause(1);
			core_rx_read_enable = 1'b0;
		end
	endtask : drain
	task automatic t_rx(input int n, input int base);
		far.send(0, 0, 1'b1, mk(9));
		send_rx(n, base, 1'b1);
		drain(n, base);
		pause(40);
		check("rx stray word", core_rx_word_valid, 0);
	endtask : t_rx
	task automatic t_rx_full();
		send_rx(223, 1000, 1'b0);
		send_rx(1, 2000, 1'b0);
		send_rx(2, 3000, 1'b0);
		drain(223, 1000);
		drain(1, 2000);
		pause(40);
		check("rx dropped packet", core_rx_word_valid, 0);
		t_rx(2, 4000);
	endtask : t_rx_full
	task automatic t_tx_fill();
		int got = 0;
		core_tx_write_enable = 1'b1;
		for (int i = 0; i < 600; i++) begin
			core_tx_word = mk(i);
			if (core_tx_write_ready === 1'b1)
				got++;
			pause(1);
		end
		core_tx_write_enable = 1'b0;
		check("tx full", core_tx_write_ready, 0);
		check("tx depth", got, 512);
		check("partial packet sent", mac_tx_word_valid, 0);
		do_reset();
		pause(100);
		check("tx cleared", mac_tx_word_valid, 0);
	endtask : t_tx_fill
	////////////////////////////////////////
	initial begin
		do_reset();
		t_tx(5, 100, 5'h16, 1'b0);
		t_tx(3, 200, 5'h04, 1'b1);
		t_tx(1, 300, 5'h16, 1'b1);
		fork
			t_tx_pair();
			t_rx(4, 600);
		join
		t_rx_full();
		t_tx_fill();
		tally_and_finish();
	end
endmodule : udp_mac_fifo_adapter_tb
